/* core/dmc_regs.sv */
// Shared configuration and reset registers with the paged port windows.
//
// Operation
// [R1] Both I2C and control channel reach registers.
// [R2] Paged reads by bits 5:4, writes by enables.
// [R3] Test range also kept separate per port.
// [R4] Address field shows address in use.
// [R5] Override bit makes address field writable.
// [R6] Reset bit 2 restarts fuse load; a write that also sets bit 1 gives only the full reset, no reload.
// [R7] Reset bit 1 resets logic and registers.
// [R8] Reset bit 0 resets logic, keeps registers.
// [R9] Input override bit picks input mode.
// [R10] Output override replaces enable and idle pins.
// [R11] Idle one, enable zero: outputs high impedance.
// [R12] Idle zero forces HS-0 while unlocked.
// [R13] Init complete set after fuse load.
// [R14] Self-clearing bits always read back zero.
`timescale 1ns/100ps
module dmc_regs
	import dmc_pkg::*;
(
	// Clock and reset.
	input  wire logic       clk,
	input  wire logic       rst_b,
	// Register access from the I2C target and the control channel.
	input  wire dmc_req_t   i2c_req,
	input  wire dmc_req_t   cc_req,
	output logic            cc_ready,
	output dmc_rsp_t        rsp,
	// Pins and device state.
	input  wire dmc_pins_t  pins,
	input  wire logic       link_locked,
	input  wire logic       fuse_load_done,
	// Effective settings.
	output logic [6:0]      own_target_address,
	output logic            input_mode,
	output logic            output_enable,
	output logic            idle_state_sel,
	output logic            parallel_out_hiz,
	output logic            force_hs0,
	// Reset and reload strobes, and the init complete status.
	output logic            full_logic_reset,
	output logic            logic_reset_keep_regs,
	output logic            reload_fuse_config,
	output logic            init_done
);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		dmc_pins_t  pins_s1;       // First synchroniser stage.
		dmc_pins_t  pins_s2;       // Second synchroniser stage.
		logic [6:0] strap_addr;    // Address caught after reset.
		logic [1:0] cap_cnt;       // Strap sampling countdown.
		logic [6:0] own_addr;      // Programmed own address.
		logic       addr_ovr;      // Address override.
		logic [4:0] rst_rsv;       // Spare bits of the reset register.
		logic [7:0] gen_cfg;       // Stored general configuration.
		logic [7:0] port_sel;      // Receive port select.
		logic       init_done;     // Fuse load complete.
		logic       pulse_full;    // Full reset strobe.
		logic       pulse_keep;    // Register-keeping reset strobe.
		logic       pulse_reload;  // Fuse reload strobe.
		logic       rsp_valid;     // Read answer valid.
		logic       rsp_src;       // Read answer destination.
		logic       rsp_mem;       // Answer comes from a page store.
		logic       rsp_port;      // Page store that answers.
		logic [7:0] rsp_data;      // Shared register read data.
	} dmc_state_t;

	// Value after reset; the strap is sampled in the first cycles after release.
	localparam dmc_state_t ST_RST = '{
		strap_addr: OWN_ADDR_RST, cap_cnt: STRAP_CAP_CYC, own_addr: OWN_ADDR_RST,
		gen_cfg: GEN_CFG_RST, port_sel: PORT_SEL_RST, default: '0};

	dmc_state_t st_reg;       // Registered state.
	dmc_state_t st_next;      // Next state.
	dmc_req_t   req;          // Access chosen this cycle.
	logic [7:0] mem_rdata0;   // Port 0 page read data.
	logic [7:0] mem_rdata1;   // Port 1 page read data.
	logic       wr_page;      // Write into the paged ranges.

	// ****************************************************************
	// Helpers
	// ****************************************************************
	// True for offsets that are held separately per receive port.
	function automatic logic is_paged(input logic [7:0] a);
		return ((a >= PAGE_LO) && (a <= PAGE_HI)) || ((a >= TEST_LO) && (a <= TEST_HI));
	endfunction

	// Maps a paged offset onto the page store index.
	function automatic logic [PAGE_AW-1:0] page_index(input logic [7:0] a);
		logic [7:0] d;
		d = (a >= TEST_LO) ? (a - TEST_LO) : (a - OFS_PORT_SEL);
		return (a >= TEST_LO) ? (PAGE_AW'(d) + TEST_IDX_BASE) : PAGE_AW'(d);
	endfunction

	// ****************************************************************
	// Access arbitration
	// ****************************************************************
	// [R1] Both access paths
	// The I2C target wins a collision; the channel waits, as its transactions
	// already tolerate long turnaround on the link.
	assign req      = i2c_req.valid ? i2c_req : cc_req;
	assign cc_ready = !i2c_req.valid;
	assign wr_page  = req.valid && req.write && is_paged(req.addr);

	// ****************************************************************
	// Effective settings
	// ****************************************************************
	// [R4] Address in use
	assign own_target_address = st_reg.addr_ovr ? st_reg.own_addr : st_reg.strap_addr;
	// [R9] Input override
	assign input_mode = st_reg.gen_cfg[CFG_IN_OVR_BIT] ? st_reg.gen_cfg[CFG_IN_SEL_BIT]
	                                                    : st_reg.pins_s2.input_sel;
	// [R10] Output override
	assign output_enable  = st_reg.gen_cfg[CFG_OUT_OVR_BIT] ? st_reg.gen_cfg[CFG_OE_BIT]
	                                                         : st_reg.pins_s2.output_drive;
	assign idle_state_sel = st_reg.gen_cfg[CFG_OUT_OVR_BIT] ? st_reg.gen_cfg[CFG_OSS_BIT]
	                                                         : st_reg.pins_s2.idle_state;
	// [R11] High impedance
	assign parallel_out_hiz = idle_state_sel && !output_enable;
	// [R12] HS-0 while unlocked
	assign force_hs0 = !link_locked && !idle_state_sel;

	// Strobes and status come straight from the state register.
	assign full_logic_reset      = st_reg.pulse_full;
	assign logic_reset_keep_regs = st_reg.pulse_keep;
	assign reload_fuse_config    = st_reg.pulse_reload;
	assign init_done             = st_reg.init_done;

	// [R2] Read port select
	// Answer data: shared value, or the page store picked at request time.
	assign rsp.valid = st_reg.rsp_valid;
	assign rsp.src   = st_reg.rsp_src;
	assign rsp.data  = !st_reg.rsp_mem ? st_reg.rsp_data
	                 : (st_reg.rsp_port ? mem_rdata1 : mem_rdata0);

	// ****************************************************************
	// Next-state logic
	// ****************************************************************
	// Computes synchronisers, strap capture, writes, reads and strobes.
	always_comb begin
		st_next = st_reg;
		st_next.pins_s1 = pins;
		st_next.pins_s2 = st_reg.pins_s1;
		st_next.pulse_full   = 1'b0;
		st_next.pulse_keep   = 1'b0;
		st_next.pulse_reload = 1'b0;
		st_next.rsp_valid    = 1'b0;
		// While the override is clear the programmed copy follows the strap.
		// Setting the override then keeps the address in use unchanged.
		if (!st_reg.addr_ovr) begin
			st_next.own_addr = st_reg.strap_addr;
		end
		// The strap settles through the synchroniser before it is caught.
		if (st_reg.cap_cnt != 2'h0) begin
			st_next.cap_cnt    = st_reg.cap_cnt - 2'h1;
			st_next.strap_addr = st_reg.pins_s2.strap_addr;
		end
		// Register writes.
		if (req.valid && req.write) begin
			unique case (req.addr)
				// Own address; the field only takes a write under override.
				OFS_OWN_ADDR: begin
					st_next.addr_ovr = req.wdata[ADDR_OVR_BIT];
					// [R5] Override gates write
					if (st_reg.addr_ovr) begin
						st_next.own_addr = req.wdata[7:1];
					end
				end
				// Reset control; the action bits are strobes, never stored.
				OFS_RESET: begin
					st_next.rst_rsv = req.wdata[7:3];
					// [R6] Fuse reload
					if (req.wdata[RST_RELOAD_BIT]) begin
						st_next.pulse_reload = 1'b1;
						st_next.init_done    = 1'b0;
					end
					// [R8] Keep registers
					st_next.pulse_keep = req.wdata[RST_KEEP_BIT];
				end
				// General configuration is stored whole.
				OFS_GEN_CFG: begin
					st_next.gen_cfg = req.wdata;
				end
				// Port select.
				OFS_PORT_SEL: begin
					st_next.port_sel = req.wdata;
				end
				// Other offsets are shared no-ops or go to the page stores.
				default: begin
				end
			endcase
		end
		// [R13] Init complete set
		// A finished load that meets a reload request wins.
		if (fuse_load_done) begin
			st_next.init_done = 1'b1;
		end
		// Register reads; page store data arrive one cycle later.
		if (req.valid && !req.write) begin
			st_next.rsp_valid = 1'b1;
			st_next.rsp_src   = !i2c_req.valid;
			st_next.rsp_port  = st_reg.port_sel[SEL_RD_LSB];
			st_next.rsp_mem   = is_paged(req.addr)
			                  && (st_reg.port_sel[SEL_RD_LSB+1] == 1'b0);
			unique case (req.addr)
				OFS_OWN_ADDR: st_next.rsp_data = {own_target_address, st_reg.addr_ovr};
				// [R14] Strobes read zero
				OFS_RESET:    st_next.rsp_data = {st_reg.rst_rsv, 3'h0};
				OFS_GEN_CFG:  st_next.rsp_data = {st_reg.gen_cfg[7], input_mode,
				                                  st_reg.gen_cfg[5:4], output_enable,
				                                  idle_state_sel, st_reg.gen_cfg[1:0]};
				OFS_DEV_STS:  st_next.rsp_data = {1'b0, st_reg.init_done, 6'h00};
				OFS_PORT_SEL: st_next.rsp_data = st_reg.port_sel;
				default:      st_next.rsp_data = 8'h00;
			endcase
		end
		// [R7] Full reset
		// Registers return to reset values; the synchronisers and the init complete
		// flag carry on so a fuse load already finished is not lost.
		if (req.valid && req.write && (req.addr == OFS_RESET)
		    && req.wdata[RST_FULL_BIT]) begin
			st_next = ST_RST;
			st_next.pins_s1    = pins;
			st_next.pins_s2    = st_reg.pins_s1;
			st_next.init_done  = st_reg.init_done || fuse_load_done;
			st_next.pulse_full = 1'b1;
		end
	end

	// Registers the state.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_reg <= ST_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// ****************************************************************
	// Page stores
	// ****************************************************************
	// [R3] Per-port test range
	// [R2] Write enables per port
	dmc_page_mem u_page0 (
		.clk   (clk),
		.we    (wr_page && st_reg.port_sel[SEL_WR0_BIT]),
		.waddr (page_index(req.addr)),
		.wdata (req.wdata),
		.raddr (page_index(req.addr)),
		.rdata (mem_rdata0)
	);

	dmc_page_mem u_page1 (
		.clk   (clk),
		.we    (wr_page && st_reg.port_sel[SEL_WR1_BIT]),
		.waddr (page_index(req.addr)),
		.wdata (req.wdata),
		.raddr (page_index(req.addr)),
		.rdata (mem_rdata1)
	);

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	logic wr_rst;  // Write to the reset register.
	assign wr_rst = req.valid && req.write && (req.addr == OFS_RESET);

	sequence s_reload_req;
		wr_rst && req.wdata[RST_RELOAD_BIT] && !req.wdata[RST_FULL_BIT] && !fuse_load_done;
	endsequence
	sequence s_reload_ack;
		reload_fuse_config && !init_done;
	endsequence

	property p_reload;
		s_reload_req |=> s_reload_ack ##1 !reload_fuse_config;
	endproperty
	a_reload: assert property (p_reload) else $error("Reload strobe missing."); // [R6]

	property p_full;
		wr_rst && req.wdata[RST_FULL_BIT] |=> full_logic_reset
			&& (st_reg.gen_cfg == GEN_CFG_RST) && !st_reg.addr_ovr ##1 !full_logic_reset;
	endproperty
	a_full: assert property (p_full) else $error("Full reset misbehaved."); // [R7]

	property p_keep;
		wr_rst && req.wdata[RST_KEEP_BIT] && !req.wdata[RST_FULL_BIT]
			|=> logic_reset_keep_regs && (st_reg.gen_cfg == $past(st_reg.gen_cfg));
	endproperty
	a_keep: assert property (p_keep) else $error("Keep-register reset wrong."); // [R8]

	property p_init;
		fuse_load_done |=> init_done;
	endproperty
	a_init: assert property (p_init) else $error("Init complete not set."); // [R13]

	property p_rd_lat;
		req.valid && !req.write |=> rsp.valid && (rsp.src == $past(!i2c_req.valid));
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("Read answer late."); // [R1]

	property p_sc_read;
		req.valid && !req.write && (req.addr == OFS_RESET) |=> (rsp.data[2:0] == 3'h0);
	endproperty
	a_sc_read: assert property (p_sc_read) else $error("Strobe bit read as one."); // [R14]

	property p_addr_ro;
		req.valid && req.write && (req.addr == OFS_OWN_ADDR) && !st_reg.addr_ovr
			&& (st_reg.cap_cnt == 2'h0) |=> (own_target_address == $past(st_reg.strap_addr));
	endproperty
	a_addr_ro: assert property (p_addr_ro) else $error("Address written while locked."); // [R5]

	property p_in_sel;
		st_reg.gen_cfg[CFG_IN_OVR_BIT] |-> (input_mode == st_reg.gen_cfg[CFG_IN_SEL_BIT]);
	endproperty
	a_in_sel: assert property (p_in_sel) else $error("Input override ignored."); // [R9]

	property p_hiz_pins;
		!st_reg.gen_cfg[CFG_OUT_OVR_BIT] && st_reg.pins_s2.idle_state
			&& !st_reg.pins_s2.output_drive |-> parallel_out_hiz && !force_hs0;
	endproperty
	a_hiz_pins: assert property (p_hiz_pins) else $error("Outputs not released."); // [R11]

	property p_hs0;
		!link_locked && !idle_state_sel |-> force_hs0 && !parallel_out_hiz;
	endproperty
	a_hs0: assert property (p_hs0) else $error("HS-0 not forced."); // [R12]

	property p_out_pins;
		!st_reg.gen_cfg[CFG_OUT_OVR_BIT] |-> (output_enable == st_reg.pins_s2.output_drive);
	endproperty
	a_out_pins: assert property (p_out_pins) else $error("Enable not from pin."); // [R10]

endmodule // dmc_regs

/* include/dmc_pkg.sv */
// Package holding the register map, field positions, reset values and carriers.
package dmc_pkg;

	// ****************************************************************
	// Register offsets and address ranges
	// ****************************************************************
	localparam logic [7:0] OFS_OWN_ADDR = 8'h00;  // Own target address.
	localparam logic [7:0] OFS_RESET    = 8'h01;  // Soft reset control.
	localparam logic [7:0] OFS_GEN_CFG  = 8'h02;  // General configuration.
	localparam logic [7:0] OFS_DEV_STS  = 8'h04;  // Device status.
	localparam logic [7:0] OFS_PORT_SEL = 8'h4C;  // Receive port select.
	localparam logic [7:0] PAGE_LO      = 8'h4D;  // First paged port offset.
	localparam logic [7:0] PAGE_HI      = 8'h7F;  // Last paged port offset.
	localparam logic [7:0] TEST_LO      = 8'hD0;  // First per-port test offset.
	localparam logic [7:0] TEST_HI      = 8'hDF;  // Last per-port test offset.

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int ADDR_OVR_BIT   = 0;  // Address override.
	localparam int RST_KEEP_BIT   = 0;  // Logic reset keeping registers.
	localparam int RST_FULL_BIT   = 1;  // Full logic reset.
	localparam int RST_RELOAD_BIT = 2;  // Fuse configuration reload.
	localparam int CFG_IN_OVR_BIT = 7;  // Input select override.
	localparam int CFG_IN_SEL_BIT = 6;  // Input select value.
	localparam int CFG_OUT_OVR_BIT = 5; // Output control override.
	localparam int CFG_OE_BIT     = 3;  // Output enable.
	localparam int CFG_OSS_BIT    = 2;  // Idle state select.
	localparam int STS_INIT_BIT   = 6;  // Init complete.
	localparam int SEL_RD_LSB     = 4;  // Read port field, bits 5:4.
	localparam int SEL_WR0_BIT    = 0;  // Write enable for port 0.
	localparam int SEL_WR1_BIT    = 1;  // Write enable for port 1.

	// ****************************************************************
	// Reset values and sizes
	// ****************************************************************
	localparam logic [6:0] OWN_ADDR_RST  = 7'h3D;  // Address before strap capture.
	localparam logic [7:0] GEN_CFG_RST   = 8'h1E;  // General configuration.
	localparam logic [7:0] PORT_SEL_RST  = 8'h01;  // Port 0 read and write.
	localparam logic [1:0] STRAP_CAP_CYC = 2'h3;   // Strap sampling cycles.
	localparam int         PAGE_AW       = 7;      // Page index width.
	localparam int         PAGE_DEPTH    = 68;     // Bytes per port page.
	localparam logic [6:0] TEST_IDX_BASE = 7'h34;  // Index of first test byte.

	// ****************************************************************
	// Carriers
	// ****************************************************************
	// One register access from the I2C target or the control channel.
	typedef struct packed {
		logic       valid;
		logic       write;
		logic [7:0] addr;
		logic [7:0] wdata;
	} dmc_req_t;

	// Read answer; src is 1 for the control channel.
	typedef struct packed {
		logic       valid;
		logic       src;
		logic [7:0] data;
	} dmc_rsp_t;

	// Strapped and pin-driven settings.
	typedef struct packed {
		logic [6:0] strap_addr;
		logic       input_sel;
		logic       output_drive;
		logic       idle_state;
	} dmc_pins_t;

endpackage

/* core/dmc_page_mem.sv */
// Per-port byte store for the paged and test register ranges.
`timescale 1ns/100ps
module dmc_page_mem
	import dmc_pkg::*;
(
	// Clock.
	input  wire logic               clk,
	// Write side.
	input  wire logic               we,
	input  wire logic [PAGE_AW-1:0] waddr,
	input  wire logic [7:0]         wdata,
	// Read side.
	input  wire logic [PAGE_AW-1:0] raddr,
	output logic [7:0]              rdata
);

	// The array is not reset; software programs it after every reset.
	logic [7:0] mem [PAGE_DEPTH];

	// Write port and registered read port.
	always_ff @(posedge clk) begin
		if (we && (waddr < PAGE_AW'(PAGE_DEPTH))) begin
			mem[waddr] <= wdata;
		end
		// Out-of-range indices read as zero.
		rdata <= (raddr < PAGE_AW'(PAGE_DEPTH)) ? mem[raddr] : 8'h00;
	end

endmodule // dmc_page_mem

/* verif/dmc_cc_model.sv */
// Control-channel initiator model on the far side of the register block.
`timescale 1ns/100ps
module dmc_cc_model
	import dmc_pkg::*;
(
	// Clock.
	input  wire logic     clk,
	// Channel side.
	output dmc_req_t      cc_req,
	input  wire logic     cc_ready,
	input  wire dmc_rsp_t rsp
);
	int unsigned refused;  // Edges at which the request was held off.

	initial begin
		cc_req  = '0;
		refused = 0;
	end

	// Channel register access.
	// The request is held until an edge sees cc_ready, then released just after it.
	// A released bus shows inverted values so stale data is never mistaken for live.
	task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
		input int gap, output logic [7:0] rd, output logic ok);
		repeat (gap) @(posedge clk);
		#1;
		cc_req = '{valid: 1'b1, write: wr, addr: a, wdata: d};
		forever begin
			@(posedge clk);
			if (cc_ready === 1'b1) break;
			refused++;
		end
		#1;
		cc_req = '{valid: 1'b0, write: 1'b0, addr: ~a, wdata: ~d};
		rd     = rsp.data;
		ok     = wr | ((rsp.valid === 1'b1) && (rsp.src === 1'b1));
	endtask
endmodule // dmc_cc_model

/* verif/tb_dmc_regs.sv */
// Self-checking testbench for the shared configuration registers.
`timescale 1ns/100ps
module tb_dmc_regs;
	import dmc_pkg::*;

	// Design connections.
	logic       clk;
	logic       rst_b;
	dmc_req_t   i2c_req;
	dmc_req_t   cc_req;
	logic       cc_ready;
	dmc_rsp_t   rsp;
	dmc_pins_t  pins;
	logic       link_locked;
	logic       fuse_load_done;
	logic [6:0] own_target_address;
	logic       input_mode, output_enable, idle_state_sel, parallel_out_hiz, force_hs0;
	logic       full_logic_reset, logic_reset_keep_regs, reload_fuse_config, init_done;
	// Bookkeeping.
	int         failures = 0;
	int         comparisons = 0;
	int         cycles = 0;
	logic [7:0] cc_data;
	logic       cc_ok;
	localparam logic [6:0] STRAP = 7'h2A;  // Strapped address chosen for the run.

	dmc_regs i_dut (.clk(clk), .rst_b(rst_b), .i2c_req(i2c_req), .cc_req(cc_req),
		.cc_ready(cc_ready), .rsp(rsp), .pins(pins), .link_locked(link_locked),
		.fuse_load_done(fuse_load_done), .own_target_address(own_target_address),
		.input_mode(input_mode), .output_enable(output_enable),
		.idle_state_sel(idle_state_sel), .parallel_out_hiz(parallel_out_hiz),
		.force_hs0(force_hs0), .full_logic_reset(full_logic_reset),
		.logic_reset_keep_regs(logic_reset_keep_regs),
		.reload_fuse_config(reload_fuse_config), .init_done(init_done));

	dmc_cc_model i_cc (.clk(clk), .cc_req(cc_req), .cc_ready(cc_ready), .rsp(rsp));

	// 40 MHz clock.
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Hang guard; the tests need well under two thousand cycles.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			report_and_stop();
		end
	end

	// Counts one comparison and reports a mismatch at once.
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask

	// I2C write; one idle edge first, so a release is never overwritten at once.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		i2c_req = '{valid: 1'b1, write: 1'b1, addr: a, wdata: d};
		@(posedge clk);
		#1;
		i2c_req = '{valid: 1'b0, write: 1'b0, addr: ~a, wdata: ~d};
	endtask

	// I2C read; the answer stands for the one cycle after the taken edge.
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		#1;
		i2c_req = '{valid: 1'b1, write: 1'b0, addr: a, wdata: 8'h00};
		@(posedge clk);
		#1;
		i2c_req = '{valid: 1'b0, write: 1'b0, addr: ~a, wdata: 8'hFF};
		check({6'h00, rsp.valid, rsp.src}, 8'h02);
		check(rsp.data, exp);
	endtask

	// Strobes seen in the cycle after a write, then all low one cycle on.
	task automatic strobe_chk(input logic [2:0] exp);
		check({5'h00, full_logic_reset, logic_reset_keep_regs, reload_fuse_config}, {5'h00, exp});
		@(posedge clk);
		#1;
		check({5'h00, full_logic_reset, logic_reset_keep_regs, reload_fuse_config}, 8'h00);
	endtask

	// Readback of the configuration byte: pins show where an override is clear.
	function automatic logic [7:0] cfg_exp(input logic [7:0] s);
		logic [7:0] v;
		v = s;
		if (!s[7]) v[6] = pins.input_sel;
		if (!s[5]) v[3:2] = {pins.output_drive, pins.idle_state};
		return v;
	endfunction

	// Address field follows the strap until the override is set.
	task automatic t_addr();
		check({1'b0, own_target_address}, {1'b0, STRAP});
		rd_chk(8'h00, {STRAP, 1'b0});
		wr(8'h00, 8'h11);
		rd_chk(8'h00, {STRAP, 1'b1});
		wr(8'h00, 8'h11);
		rd_chk(8'h00, 8'h11);
		check({1'b0, own_target_address}, 8'h08);
	endtask

	// Fuse reload pulse, self-clearing readback and init status.
	task automatic t_reload();
		wr(8'h01, 8'h04);
		strobe_chk(3'h1);
		check({7'h00, init_done}, 8'h00);
		rd_chk(8'h01, 8'h00);
		fuse_load_done = 1'b1;
		@(posedge clk);
		#1;
		fuse_load_done = 1'b0;
		rd_chk(8'h04, 8'h40);
	endtask

	// Both overrides set or clear together, with every enable, idle and lock combination.
	task automatic t_cfg();
		logic [7:0] s;
		logic [7:0] v;
		for (int i = 0; i < 16; i++) begin
			s           = {i[3], i[2], i[3], 1'b1, i[1], i[0], 2'b10};
			link_locked = i[2];
			wr(8'h02, s);
			v = cfg_exp(s);
			rd_chk(8'h02, v);
			check({3'h0, input_mode, output_enable, idle_state_sel, parallel_out_hiz, force_hs0},
				{3'h0, v[6], v[3], v[2], v[2] & ~v[3], ~link_locked & ~v[2]});
		end
	endtask

	// Logic reset keeping registers, then full reset restoring defaults.
	task automatic t_resets();
		wr(8'h02, 8'hA1);
		wr(8'h01, 8'h01);
		strobe_chk(3'h2);
		rd_chk(8'h02, cfg_exp(8'hA1));
		wr(8'h4C, 8'h12);
		wr(8'h01, 8'h02);
		strobe_chk(3'h4);
		repeat (6) @(posedge clk);
		#1;
		rd_chk(8'h01, 8'h00);
		rd_chk(8'h02, cfg_exp(8'h1E));
		rd_chk(8'h00, {STRAP, 1'b0});
		rd_chk(8'h4C, 8'h01);
	endtask

	// Paged range per port, test range read back on port 1, plus an unmapped offset.
	task automatic t_paged();
		wr(8'h4C, 8'h03);
		wr(8'h50, 8'hA5);
		wr(8'hD3, 8'h5A);
		wr(8'h4C, 8'h01);
		wr(8'h50, 8'h11);
		rd_chk(8'h50, 8'h11);
		wr(8'h4C, 8'h10);
		rd_chk(8'h50, 8'hA5);
		rd_chk(8'hD3, 8'h5A);
		wr(8'h4C, 8'h20);
		rd_chk(8'h50, 8'h00);
		wr(8'h90, 8'h77);
		rd_chk(8'h90, 8'h00);
	endtask

	// Channel access, slow and then colliding with an I2C read.
	task automatic t_channel();
		i_cc.access(1'b1, 8'h02, 8'hE5, 3, cc_data, cc_ok);
		i_cc.access(1'b0, 8'h02, 8'h00, 0, cc_data, cc_ok);
		check({cc_ok, cc_data[7:1]}, 8'h80 | (cfg_exp(8'hE5) >> 1));
		fork
			rd_chk(8'h02, cfg_exp(8'hE5));
			i_cc.access(1'b0, 8'h02, 8'h00, 1, cc_data, cc_ok);
		join
		check({cc_ok, 6'h00, i_cc.refused > 0}, 8'h81);
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic report_and_stop();
		$display("comparisons=%0d failures=%0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Main sequence.
	initial begin
		rst_b          = 1'b0;
		i2c_req        = '0;
		link_locked    = 1'b0;
		fuse_load_done = 1'b0;
		pins           = '{strap_addr: STRAP, input_sel: 1'b1, output_drive: 1'b0,
			idle_state: 1'b1};
		@(posedge clk);
		#1;
		check({1'b0, own_target_address}, 8'h3D);
		repeat (11) @(posedge clk);
		#1;
		rst_b = 1'b1;
		repeat (6) @(posedge clk);
		#1;
		t_addr();
		t_reload();
		t_cfg();
		t_resets();
		t_paged();
		t_channel();
		report_and_stop();
	end
endmodule // tb_dmc_regs
